// ---- src/tkc_sensor.sv ----
// Touch key sensor: AHB-Lite registers, gate timer, counter, filters
`default_nettype none
// Functional notes
// - Mode swaps internal and sensing clock roles
// - One 24-bit timer, one 24-bit counter
// - Start clears counter, loads timer, runs
// - Timer expiry latches count, raises flag
// - Each capture updates slow and fast averages
// - Auto repeats silently, widths cut to 16
// - Auto wakes when fast exceeds slow+threshold
// - Clock choice picks fast or slow oscillator
// - Busy reads back; writing that bit starts
// - Start: single capture, or continuous in auto
// - Writing start zero aborts to idle
// - 255-bit random sequence doubles charge current
// - Fast comparator bit selects speed and scale
// - Multiplier bit selects five-times current
// - Four-bit field sets 0.125 uA steps
// - Slow filter raw or 15/16..127/128 weights
// - Fast filter raw or /2../16 weights
module tkc_sensor #(
  parameter int SLOW_DIV = 4
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  input  wire logic            sense_osc,
  output logic [31:0]          hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic                 irq,
  output tkc_pkg::tkc_afe_t    afe
);
  localparam logic [15:0] DIV_LAST = 16'(SLOW_DIV - 1);

  // ==========================================
  // Declarations
  tkc_pkg::tkc_state_t state, next_state;
  tkc_pkg::tkc_afe_t   next_afe;
  logic        s1, s2, s3, stable, stable_d;
  logic        next_s1, next_s2, next_s3, next_stable, next_stable_d;
  logic [15:0] div, next_div;
  logic        a_wr, next_a_wr;
  logic [31:0] a_addr, next_a_addr, next_hrdata;
  logic        en, mode, auto, ien, flag;
  logic        next_en, next_mode, next_auto, next_ien, next_flag;
  logic [1:0]  clk_sel, next_clk_sel;
  logic [7:0]  ana, next_ana, filt, next_filt, lfsr, next_lfsr;
  logic [23:0] period, next_period, count_cap, next_cap;
  logic [23:0] fast, next_fast, slow, next_slow;
  logic [23:0] timer, next_timer, counter, next_counter;
  logic [15:0] thresh, next_thresh;
  logic        next_irq, take, busy, sense_tick, int_tick;
  logic        tim_tick, cnt_tick, wr_ctrl, abort, start_go;
  logic        cap_evt, detect, set_flag;
  logic [23:0] wmask, cap_val, nf, ns;
  logic [2:0]  sh_s, sh_f;

  // ==========================================
  // Moving average helper
  function automatic logic [23:0] avg_f(input logic [23:0] o,
                                        input logic [23:0] n,
                                        input logic [2:0]  sh);
    logic [31:0] s;
    s = {8'h00, n} + ({8'h00, o} << sh) - {8'h00, o};
    avg_f = (sh == 3'h0) ? n : s[23 + sh -: 24];
  endfunction

  // ==========================================
  // Register read mux
  function automatic logic [31:0] rd_mux(input logic [31:0] a);
    case (a)
      tkc_pkg::A_CTRL:   rd_mux = {24'h0, en, mode, clk_sel, auto, ien, flag, busy};
      tkc_pkg::A_ANA:    rd_mux = {24'h0, ana};
      tkc_pkg::A_FILT:   rd_mux = {24'h0, filt};
      tkc_pkg::A_PERIOD: rd_mux = {8'h0, period};
      tkc_pkg::A_COUNT:  rd_mux = {8'h0, count_cap};
      tkc_pkg::A_FAST:   rd_mux = {8'h0, fast};
      tkc_pkg::A_SLOW:   rd_mux = {8'h0, slow};
      tkc_pkg::A_THRESH: rd_mux = {16'h0, thresh};
      default:           rd_mux = 32'h0;
    endcase
  endfunction

  // ==========================================
  // Sensing input synchroniser and clock ticks
  always_comb begin
    next_s1       = sense_osc;
    next_s2       = s1;
    next_s3       = s2;
    next_stable   = (s2 == s3) ? s3 : stable;
    next_stable_d = stable;
    next_div      = (div == DIV_LAST) ? 16'h0 : div + 16'h1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1       <= 1'b0;
      s2       <= 1'b0;
      s3       <= 1'b0;
      stable   <= 1'b0;
      stable_d <= 1'b0;
      div      <= 16'h0;
    end else begin
      s1       <= next_s1;
      s2       <= next_s2;
      s3       <= next_s3;
      stable   <= next_stable;
      stable_d <= next_stable_d;
      div      <= next_div;
    end
  end

  assign sense_tick = stable & ~stable_d;
  assign int_tick   = ~clk_sel[1] | (div == DIV_LAST);
  assign tim_tick   = mode ? int_tick : sense_tick;
  assign cnt_tick   = mode ? sense_tick : int_tick;

  // ==========================================
  // AHB-Lite slave
  assign take    = hsel & htrans[1] & hready;
  assign wr_ctrl = a_wr & (a_addr == tkc_pkg::A_CTRL);

  always_comb begin
    next_a_wr   = take & hwrite & (hsize == tkc_pkg::SIZE_WORD);
    next_a_addr = take ? haddr : a_addr;
    next_hrdata = (take & ~hwrite) ? rd_mux(haddr) : 32'h0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr      <= 1'b0;
      a_addr    <= 32'h0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      a_wr      <= next_a_wr;
      a_addr    <= next_a_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ==========================================
  // Measurement core
  assign busy     = (state == tkc_pkg::TKC_RUN);
  assign wmask    = auto ? tkc_pkg::MASK_AUTO : tkc_pkg::MASK_FULL;
  assign abort    = ~en | (wr_ctrl & ~(hwdata[tkc_pkg::B_START]
                                      & hwdata[tkc_pkg::B_EN]));
  assign start_go = ~busy & wr_ctrl & hwdata[tkc_pkg::B_START]
                    & hwdata[tkc_pkg::B_EN];
  assign cap_val  = (counter + {23'h0, cnt_tick}) & wmask;
  assign sh_s     = (filt[7:4] == 4'h0 || filt[7:4] > 4'h4) ? 3'h0
                    : 3'(filt[7:4] + 4'h3);
  assign sh_f     = (filt[3:0] > 4'h4) ? 3'h4 : filt[2:0];
  assign nf       = avg_f(fast, cap_val, sh_f) & wmask;
  assign ns       = avg_f(slow, cap_val, sh_s) & wmask;
  assign cap_evt  = busy & ~abort & tim_tick & (timer <= 24'h1);
  assign detect   = auto & ({1'b0, nf} > {1'b0, ns} + {9'h0, thresh});

  always_comb begin
    next_state   = state;
    next_timer   = timer;
    next_counter = counter;
    next_cap     = count_cap;
    next_fast    = fast;
    next_slow    = slow;
    next_en      = en;
    next_mode    = mode;
    next_clk_sel = clk_sel;
    next_auto    = auto;
    next_ien     = ien;
    next_ana     = ana;
    next_filt    = filt;
    next_period  = period;
    next_thresh  = thresh;
    set_flag     = 1'b0;
    if (wr_ctrl) begin
      next_en      = hwdata[tkc_pkg::B_EN];
      next_mode    = hwdata[tkc_pkg::B_MODE];
      next_clk_sel = hwdata[tkc_pkg::B_CLK +: 2];
      next_auto    = hwdata[tkc_pkg::B_AUTO];
      next_ien     = hwdata[tkc_pkg::B_IEN];
    end
    if (a_wr && a_addr == tkc_pkg::A_ANA) next_ana = hwdata[7:0] & tkc_pkg::ANA_MASK;
    if (a_wr && a_addr == tkc_pkg::A_FILT) next_filt = hwdata[7:0];
    if (a_wr && a_addr == tkc_pkg::A_PERIOD) next_period = hwdata[23:0];
    if (a_wr && a_addr == tkc_pkg::A_THRESH) next_thresh = hwdata[15:0];
    if (a_wr && a_addr == tkc_pkg::A_FAST) next_fast = hwdata[23:0];
    if (a_wr && a_addr == tkc_pkg::A_SLOW) next_slow = hwdata[23:0];
    unique case (state)
      tkc_pkg::TKC_IDLE: begin
        if (start_go) begin
          next_state   = tkc_pkg::TKC_RUN;
          next_counter = 24'h0;
          next_timer   = period & (hwdata[tkc_pkg::B_AUTO] ? tkc_pkg::MASK_AUTO
                                                            : tkc_pkg::MASK_FULL);
        end
      end
      tkc_pkg::TKC_RUN: begin
        if (abort) begin
          next_state = tkc_pkg::TKC_IDLE;
        end else begin
          next_counter = cap_val;
          if (cap_evt) begin
            next_cap  = cap_val;
            next_fast = nf;
            next_slow = ns;
            if (!auto || detect) begin
              next_state = tkc_pkg::TKC_IDLE;
              set_flag   = 1'b1;
            end else begin
              next_timer   = period & wmask;
              next_counter = 24'h0;
            end
          end else if (tim_tick) begin
            next_timer = (timer - 24'h1) & wmask;
          end
        end
      end
    endcase
    next_flag = set_flag | (flag & ~(wr_ctrl & ~hwdata[tkc_pkg::B_FLAG]));
    next_irq  = flag & ien;
    next_lfsr = ~ana[tkc_pkg::B_PRS] ? tkc_pkg::LFSR_SEED
              : sense_tick ? {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]}
              : lfsr;
    next_afe.fast_comp     = ana[tkc_pkg::B_HSPD];
    next_afe.mult5         = ana[tkc_pkg::B_MUL];
    next_afe.current       = ana[3:0];
    next_afe.charge_double = ana[tkc_pkg::B_PRS] & lfsr[0];
    next_afe.pin_enable    = en;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= tkc_pkg::TKC_IDLE;
      timer     <= 24'h0;
      counter   <= 24'h0;
      count_cap <= 24'h0;
      fast      <= 24'h0;
      slow      <= 24'h0;
      en        <= tkc_pkg::CTRL_RST[tkc_pkg::B_EN];
      mode      <= tkc_pkg::CTRL_RST[tkc_pkg::B_MODE];
      clk_sel   <= tkc_pkg::CTRL_RST[tkc_pkg::B_CLK +: 2];
      auto      <= tkc_pkg::CTRL_RST[tkc_pkg::B_AUTO];
      ien       <= tkc_pkg::CTRL_RST[tkc_pkg::B_IEN];
      flag      <= tkc_pkg::CTRL_RST[tkc_pkg::B_FLAG];
      ana       <= tkc_pkg::ANA_RST;
      filt      <= tkc_pkg::FILT_RST;
      period    <= tkc_pkg::PERIOD_RST;
      thresh    <= tkc_pkg::THRESH_RST;
      lfsr      <= tkc_pkg::LFSR_SEED;
      irq       <= 1'b0;
      afe       <= '0;
    end else begin
      state     <= next_state;
      timer     <= next_timer;
      counter   <= next_counter;
      count_cap <= next_cap;
      fast      <= next_fast;
      slow      <= next_slow;
      en        <= next_en;
      mode      <= next_mode;
      clk_sel   <= next_clk_sel;
      auto      <= next_auto;
      ien       <= next_ien;
      flag      <= next_flag;
      ana       <= next_ana;
      filt      <= next_filt;
      period    <= next_period;
      thresh    <= next_thresh;
      lfsr      <= next_lfsr;
      irq       <= next_irq;
      afe       <= next_afe;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_started;
    busy && counter == 24'h0;
  endsequence
  sequence s_stopped;
    !busy ##1 !busy;
  endsequence

  property p_mode0_count;
    busy && !mode && int_tick && !sense_tick && !abort
      |=> counter == (($past(counter) + 24'h1) & $past(wmask));
  endproperty
  a_mode0_count: assert property (p_mode0_count) else $error("counter missed tick");

  property p_start;
    start_go |=> s_started;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_capture;
    cap_evt && !auto |=> count_cap == $past(cap_val) && flag && !busy;
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost");

  property p_raw_filt;
    cap_evt && filt == 8'h00 |=> fast == count_cap && slow == count_cap;
  endproperty
  a_raw_filt: assert property (p_raw_filt) else $error("filters not updated");

  property p_auto_quiet;
    busy && auto && !flag && cap_evt && !detect |=> busy && !flag
      && timer[23:16] == 8'h00 && count_cap[23:16] == 8'h00;
  endproperty
  a_auto_quiet: assert property (p_auto_quiet) else $error("auto capture wrong");

  property p_wake;
    cap_evt && detect |=> flag ##1 s_stopped;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missed");

  property p_busy_read;
    take && !hwrite && haddr == tkc_pkg::A_CTRL |=> hrdata[0] == $past(busy);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy readback wrong");

  property p_abort;
    busy && wr_ctrl && !hwdata[tkc_pkg::B_START] |=> !busy;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");

  property p_prbs;
    lfsr != 8'h00 && (ana[tkc_pkg::B_PRS] || afe.charge_double == 1'b0
      || $past(ana[tkc_pkg::B_PRS]));
  endproperty
  a_prbs: assert property (p_prbs) else $error("random sequence broken");

  property p_irq;
    ##1 irq == $past(flag && ien);
  endproperty
  a_irq: assert property (p_irq) else $error("irq gating wrong");
endmodule // tkc_sensor
`default_nettype wire

// ---- inc/tkc_pkg.sv ----
// Touch key sensor package: register map, fields, reset values, types
`default_nettype none
package tkc_pkg;
  // ==========================================
  // Register indices and byte addresses
  localparam logic [31:0] IDX_CTRL   = 32'h0000a130;
  localparam logic [31:0] IDX_ANA    = 32'h0000a131;
  localparam logic [31:0] IDX_FILT   = 32'h0000a132;
  localparam logic [31:0] IDX_PERIOD = 32'h0000a134;
  localparam logic [31:0] IDX_COUNT  = 32'h0000a135;
  localparam logic [31:0] IDX_FAST   = 32'h0000a136;
  localparam logic [31:0] IDX_SLOW   = 32'h0000a137;
  localparam logic [31:0] IDX_THRESH = 32'h0000a138;
  localparam logic [31:0] A_CTRL     = {IDX_CTRL[29:0], 2'b00};
  localparam logic [31:0] A_ANA      = {IDX_ANA[29:0], 2'b00};
  localparam logic [31:0] A_FILT     = {IDX_FILT[29:0], 2'b00};
  localparam logic [31:0] A_PERIOD   = {IDX_PERIOD[29:0], 2'b00};
  localparam logic [31:0] A_COUNT    = {IDX_COUNT[29:0], 2'b00};
  localparam logic [31:0] A_FAST     = {IDX_FAST[29:0], 2'b00};
  localparam logic [31:0] A_SLOW     = {IDX_SLOW[29:0], 2'b00};
  localparam logic [31:0] A_THRESH   = {IDX_THRESH[29:0], 2'b00};
  // ==========================================
  // Control fields
  localparam int B_EN    = 7;
  localparam int B_MODE  = 6;
  localparam int B_CLK   = 4;
  localparam int B_AUTO  = 3;
  localparam int B_IEN   = 2;
  localparam int B_FLAG  = 1;
  localparam int B_START = 0;
  // ==========================================
  // Analog fields
  localparam int B_HSPD = 7;
  localparam int B_PRS  = 6;
  localparam int B_MUL  = 4;
  localparam logic [7:0] ANA_MASK = 8'hdf;
  // ==========================================
  // Reset values and widths
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  ANA_RST    = 8'h00;
  localparam logic [7:0]  FILT_RST   = 8'h00;
  localparam logic [23:0] PERIOD_RST = 24'h000000;
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [7:0]  LFSR_SEED  = 8'h01;
  localparam logic [23:0] MASK_FULL  = 24'hffffff;
  localparam logic [23:0] MASK_AUTO  = 24'h00ffff;
  localparam logic [2:0]  SIZE_WORD  = 3'h2;
  // ==========================================
  // Types
  typedef enum logic {TKC_IDLE, TKC_RUN} tkc_state_t;
  typedef struct packed {
    logic       fast_comp;
    logic       mult5;
    logic [3:0] current;
    logic       charge_double;
    logic       pin_enable;
  } tkc_afe_t;
endpackage
`default_nettype wire

// ---- testbench/tkc_keypad.sv ----
// Key pad model: relaxation oscillator that slows when touched
`default_nettype none
module tkc_keypad (
  input  wire logic       hclk,
  input  wire logic       run,
  input  wire logic [7:0] half,
  output logic            sense_osc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  logic       osc = 1'b0;
  assign sense_osc = osc;
  // ==========================================
  // Oscillator, still and low while the pad is not enabled
  always @(posedge hclk) begin
    if (!run) begin
      cnt <= 8'h00;
      osc <= 1'b0;
    end else if (cnt + 8'h01 >= half) begin
      cnt <= 8'h00;
      osc <= ~osc;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // tkc_keypad
`default_nettype wire

// ---- testbench/tkc_sensor_bench.sv ----
// Bench for the touch key sensor: bus tasks, captures, auto wake
`default_nettype none
module tkc_sensor_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SD = 2;
  localparam int T  = 40;
  localparam int F0 = 100;
  localparam int S0 = 200;
  logic               hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, sense_osc;
  logic [31:0]        haddr, hwdata, hrdata, c, fe, se;
  logic [1:0]         htrans, ck;
  logic [2:0]         hsize;
  logic [7:0]         half;
  logic [1:0]         seen = 2'b00;
  tkc_pkg::tkc_afe_t  afe;
  int                 err_count = 0;
  int                 num_checks = 0;
  int                 n, d, fk, sn;
  logic [7:0]         av [3] = '{8'hdf, 8'h05, 8'h90};
  logic [7:0]         ae [3] = '{8'hfe, 8'h14, 8'hc0};
  assign hready = hreadyout;
  tkc_sensor #(.SLOW_DIV(SD)) tkc_sensor_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .sense_osc(sense_osc), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irq(irq), .afe(afe));
  tkc_keypad tkc_keypad_i (.hclk(hclk), .run(afe.pin_enable), .half(half),
    .sense_osc(sense_osc));
  // ==========================================
  // Clock, charge current watch, watchdog
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (afe.pin_enable === 1'b1) seen[afe.charge_double] <= 1'b1;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    conclude();
  end
  // ==========================================
  // Compare and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    num_checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic wt();
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] dt,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= tkc_pkg::SIZE_WORD;
    wt();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= dt;
    wt();
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] dt);
    logic [31:0] r;
    bus(a, 1'b1, dt, r);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    bus(a, 1'b0, 32'h0, r);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(r, e);
  endtask
  task automatic wait_irq(output int m);
    m = 0;
    while (irq !== 1'b1 && m < 4000) begin
      @(posedge hclk);
      m++;
    end
    if (m >= 4000) chk({31'h0, irq}, 32'h1);
  endtask
  task automatic conclude();
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = tkc_pkg::SIZE_WORD;
    hwdata = 32'h0;
    half = 8'd2;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(tkc_pkg::A_CTRL, 32'h0);
    chk({30'h0, hresp, hreadyout}, 32'h1);
    rdc(tkc_pkg::A_ANA, 32'h0);
    rdc(tkc_pkg::A_FILT, 32'h0);
    rdc(tkc_pkg::A_THRESH + 32'h4, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(tkc_pkg::A_ANA, {24'h0, av[i]});
      rdc(tkc_pkg::A_ANA, {24'h0, av[i] & tkc_pkg::ANA_MASK});
      chk({24'h0, afe}, {24'h0, ae[i]});
    end
    // Single captures over every clock choice and filter codes 0 to 5
    wr(tkc_pkg::A_ANA, 32'h40);
    for (int k = 0; k < 6; k++) begin
      ck = k[1:0];
      d = ck[1] ? SD : 1;
      wr(tkc_pkg::A_PERIOD, T);
      wr(tkc_pkg::A_FAST, F0);
      wr(tkc_pkg::A_SLOW, S0);
      wr(tkc_pkg::A_FILT, {24'h0, k[3:0], k[3:0]});
      wr(tkc_pkg::A_CTRL, {24'h0, 2'b11, ck, 4'b0111});
      wait_irq(n);
      chk_rng(n, T * d, T * d + d + 4);
      rd(tkc_pkg::A_COUNT, c);
      chk_rng(c, T * d / 4 - 1, T * d / 4 + 2);
      fk = (k > 4) ? 4 : k;
      sn = (k >= 1 && k <= 4) ? k + 3 : 0;
      fe = (fk == 0) ? c : (c + ((1 << fk) - 1) * F0) >> fk;
      se = (sn == 0) ? c : (c + ((1 << sn) - 1) * S0) >> sn;
      rdc(tkc_pkg::A_FAST, fe);
      rdc(tkc_pkg::A_SLOW, se);
      rdc(tkc_pkg::A_CTRL, {24'h0, 2'b11, ck, 4'b0110});
      wr(tkc_pkg::A_CTRL, {24'h0, 2'b11, ck, 4'b0100});
      rdc(tkc_pkg::A_CTRL, {24'h0, 2'b11, ck, 4'b0100});
      chk({31'h0, irq}, 32'h0);
    end
    chk({30'h0, seen}, 32'h3);
    // Abort a long capture
    wr(tkc_pkg::A_PERIOD, 32'h1000);
    wr(tkc_pkg::A_CTRL, 32'hc5);
    rdc(tkc_pkg::A_CTRL, 32'hc5);
    wr(tkc_pkg::A_CTRL, 32'hc4);
    rdc(tkc_pkg::A_CTRL, 32'hc4);
    // Auto detection with a touch that slows the pad
    wr(tkc_pkg::A_PERIOD, 32'h10004);
    wr(tkc_pkg::A_FAST, 32'd16);
    wr(tkc_pkg::A_SLOW, 32'd16);
    wr(tkc_pkg::A_THRESH, 32'd8);
    wr(tkc_pkg::A_FILT, 32'h40);
    wr(tkc_pkg::A_CTRL, 32'h8f);
    repeat (300) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    rdc(tkc_pkg::A_CTRL, 32'h8d);
    half <= 8'd4;
    wait_irq(n);
    chk_rng(n, 1, 400);
    rdc(tkc_pkg::A_CTRL, 32'h8e);
    rd(tkc_pkg::A_FAST, c);
    chk_rng(c, 25, 33);
    wr(tkc_pkg::A_CTRL, 32'h8a);
    rdc(tkc_pkg::A_CTRL, 32'h8a);
    chk({31'h0, irq}, 32'h0);
    wr(tkc_pkg::A_CTRL, 32'h0);
    rdc(tkc_pkg::A_CTRL, 32'h0);
    conclude();
  end
endmodule // tkc_sensor_bench
`default_nettype wire
